// ---- hdl/llc_dispatch.v ----
// link-layer dispatch for the single-wire front-end: sorts payloads, runs the activation layer
// assumes MAC framing/CRC are outside; received payload bytes arrive one per cycle, first byte flagged
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "llc_dispatch_regs.vh"
module llc_dispatch (
   // clock and reset
   input wire i_clk,
   input wire i_rst,
   // axi4-lite write
   input wire [11:0] i_awaddr,
   input wire i_awvalid,
   output wire o_awready,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   input wire i_wvalid,
   output wire o_wready,
   output reg [1:0] o_bresp,
   output reg o_bvalid,
   input wire i_bready,
   // axi4-lite read
   input wire [11:0] i_araddr,
   input wire i_arvalid,
   output wire o_arready,
   output reg [31:0] o_rdata,
   output reg [1:0] o_rresp,
   output reg o_rvalid,
   input wire i_rready,
   // link activation and received payload bytes
   input wire i_activated,
   input wire [7:0] i_rx_byte,
   input wire i_rx_valid,
   input wire i_rx_first,
   input wire i_rx_last,
   input wire i_rx_bad,
   // shdlc side status
   input wire i_shdlc_established,
   input wire i_shdlc_all_acked,
   // dispatched payload stream
   output reg [7:0] o_out_byte,
   output reg o_out_shdlc,
   output reg o_out_legacy,
   output reg o_out_last,
   // activation frame transmit
   output reg [7:0] o_tx_byte,
   output reg o_tx_valid,
   output reg o_tx_last,
   input wire i_tx_ready,
   // status
   output reg [1:0] o_recover_owner,
   output reg o_legacy_open,
   output reg o_ext_fast_ok,
   output reg o_ext_slow_ok,
   output reg o_id_fail
);
// ****************************************
// bus slave
// ****************************************
reg aw_got_r;
reg w_got_r;
reg [11:0] awaddr_r;
reg [31:0] wdata_r;
reg [3:0] wstrb_r;
reg [15:0] idref_r;
reg want_legacy_r;
reg pwr_full_r;
reg rf_cause_r;
reg send_pwr_r;
wire wr_go;
assign o_awready = ~aw_got_r & ~o_bvalid;
assign o_wready = ~w_got_r & ~o_bvalid;
assign o_arready = ~o_rvalid;
assign wr_go = aw_got_r & w_got_r & ~o_bvalid;
// ****************************************
// receive state
// ****************************************
reg [1:0] cur_llc_r;
reg is_act_r;
reg [2:0] act_code_r;
reg act_inf_r;
reg [2:0] act_cnt_r;
reg [7:0] act_d0_r;
reg [7:0] act_d1_r;
reg [7:0] cap_r;
reg cap_seen_r;
reg sync_seen_r;
reg id_ok_r;
reg act_done_r;
reg open_legacy_req_r;
wire [2:0] top3;
wire link_up;
assign top3 = i_rx_byte[7:5];
assign link_up = i_shdlc_established | o_legacy_open;
// tx engine for power select frame
localparam TX_IDLE = 2'h0;
localparam TX_CTRL = 2'h1;
localparam TX_DATA = 2'h2;
localparam TX_INFO = 2'h3;
reg [1:0] tx_st_r;
always @(posedge i_clk or posedge i_rst) begin
   if (i_rst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
      o_rvalid <= 1'b0;
      o_rresp <= 2'h0;
      o_rdata <= 32'h00000000;
      idref_r <= `IDREF_RESET;
      want_legacy_r <= 1'b0;
      pwr_full_r <= 1'b0;
      rf_cause_r <= 1'b0;
      send_pwr_r <= 1'b0;
   end else begin
      if (i_awvalid & o_awready) begin
         aw_got_r <= 1'b1;
         awaddr_r <= i_awaddr;
      end
      if (i_wvalid & o_wready) begin
         w_got_r <= 1'b1;
         wdata_r <= i_wdata;
         wstrb_r <= i_wstrb;
      end
      if (send_pwr_r & (tx_st_r == TX_CTRL))
         send_pwr_r <= 1'b0;
      if (wr_go) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         o_bvalid <= 1'b1;
         o_bresp <= 2'h0;
         case (awaddr_r)
            `REG_CTRL: begin
               if (wstrb_r[0]) begin
                  want_legacy_r <= wdata_r[0];
                  pwr_full_r <= wdata_r[1];
                  rf_cause_r <= wdata_r[2];
               end
            end
            `REG_IDREF: begin
               if (wstrb_r[0])
                  idref_r[7:0] <= wdata_r[7:0];
               if (wstrb_r[1])
                  idref_r[15:8] <= wdata_r[15:8];
            end
            `REG_TXCMD: begin
               // no activation frames once a link layer owns the wire
               if (wstrb_r[0] & wdata_r[0] & ~link_up)
                  send_pwr_r <= 1'b1;
            end
            `REG_STATUS, `REG_RXINFO: o_bresp <= 2'h2;
            default: o_bresp <= 2'h2;
         endcase
      end else if (o_bvalid & i_bready)
         o_bvalid <= 1'b0;
      if (i_arvalid & o_arready) begin
         o_rvalid <= 1'b1;
         o_rresp <= 2'h0;
         case (i_araddr)
            `REG_CTRL: o_rdata <= {29'h0, rf_cause_r, pwr_full_r, want_legacy_r};
            `REG_STATUS: o_rdata <= {22'h0, act_done_r, sync_seen_r, id_ok_r, o_id_fail,
               o_legacy_open, i_shdlc_established, o_recover_owner, cur_llc_r};
            `REG_IDREF: o_rdata <= {16'h0, idref_r};
            `REG_RXINFO: o_rdata <= {8'h0, act_d1_r, act_d0_r, cap_r};
            `REG_TXCMD: o_rdata <= {31'h0, send_pwr_r};
            default: begin
               o_rdata <= 32'h00000000;
               o_rresp <= 2'h2;
            end
         endcase
      end else if (o_rvalid & i_rready)
         o_rvalid <= 1'b0;
   end
end
// ****************************************
// receive dispatch and activation layer
// ****************************************
always @(posedge i_clk or posedge i_rst) begin
   if (i_rst) begin
      cur_llc_r <= `OWN_ACT;
      o_recover_owner <= `OWN_ACT;
      is_act_r <= 1'b0;
      act_code_r <= 3'h0;
      act_inf_r <= 1'b0;
      act_cnt_r <= 3'h0;
      act_d0_r <= 8'h00;
      act_d1_r <= 8'h00;
      cap_r <= 8'h00;
      cap_seen_r <= 1'b0;
      sync_seen_r <= 1'b0;
      id_ok_r <= 1'b0;
      act_done_r <= 1'b0;
      o_legacy_open <= 1'b0;
      o_id_fail <= 1'b0;
      o_ext_fast_ok <= 1'b0;
      o_ext_slow_ok <= 1'b0;
      o_out_byte <= 8'h00;
      o_out_shdlc <= 1'b0;
      o_out_legacy <= 1'b0;
      o_out_last <= 1'b0;
   end else if (~i_activated) begin
      // interface down: next activation restarts in the activation layer
      cur_llc_r <= `OWN_ACT;
      o_recover_owner <= `OWN_ACT;
      o_legacy_open <= 1'b0;
      o_id_fail <= 1'b0;
      cap_seen_r <= 1'b0;
      sync_seen_r <= 1'b0;
      id_ok_r <= 1'b0;
      act_done_r <= 1'b0;
      o_ext_fast_ok <= 1'b0;
      o_ext_slow_ok <= 1'b0;
      o_out_shdlc <= 1'b0;
      o_out_legacy <= 1'b0;
      o_out_last <= 1'b0;
   end else begin
      o_out_shdlc <= 1'b0;
      o_out_legacy <= 1'b0;
      o_out_last <= 1'b0;
      if (i_shdlc_established)
         act_done_r <= 1'b1;
      // legacy open only from an activated, acked and verified link
      if (open_legacy_req_r & ~o_legacy_open)
         o_legacy_open <= 1'b1;
      if (i_rx_valid & i_rx_bad) begin
         // corrupt frame: recovery of the layer that owned the last good one
         is_act_r <= 1'b0;
      end else if (i_rx_valid) begin
         o_out_byte <= i_rx_byte;
         if (i_rx_first) begin
            // control byte picks the layer
            if (i_rx_byte[7]) begin
               cur_llc_r <= `OWN_SHDLC;
               is_act_r <= 1'b0;
               o_out_shdlc <= 1'b1;
               o_legacy_open <= 1'b0;
            end else if (top3 == `LLC_ACT_TOP) begin
               cur_llc_r <= `OWN_ACT;
               // hint flag deliberately unused
               is_act_r <= ~link_up;
               act_code_r <= i_rx_byte[2:0];
               act_inf_r <= i_rx_byte[`ACT_INF_BIT];
               act_cnt_r <= 3'h0;
            end else if (top3 == `LLC_LEG_TOP) begin
               cur_llc_r <= `OWN_LEG;
               is_act_r <= 1'b0;
               // card-started legacy traffic is dropped until the front-end opens the session
               o_out_legacy <= o_legacy_open;
            end else
               is_act_r <= 1'b0;
         end else begin
            o_out_shdlc <= (cur_llc_r == `OWN_SHDLC);
            o_out_legacy <= (cur_llc_r == `OWN_LEG) & o_legacy_open;
            if (is_act_r) begin
               if (act_cnt_r != 3'h7)
                  act_cnt_r <= act_cnt_r + 3'h1;
               if (act_cnt_r == 3'h0)
                  act_d0_r <= i_rx_byte;
               if (act_cnt_r == 3'h1)
                  act_d1_r <= i_rx_byte;
            end
         end
         o_out_last <= i_rx_last & (cur_llc_r != `OWN_ACT) & ~i_rx_first;
         if (i_rx_last) begin
            o_recover_owner <= i_rx_first ? (i_rx_byte[7] ? `OWN_SHDLC :
               ((top3 == `LLC_LEG_TOP) ? `OWN_LEG : `OWN_ACT)) : cur_llc_r;
            // identity sync: two value bytes, then optional capability byte
            if (is_act_r & ~i_rx_first & (act_code_r == `ACT_CODE_SYNC)) begin
               sync_seen_r <= 1'b1;
               if (act_cnt_r == 3'h1) begin
                  id_ok_r <= ({act_d0_r, i_rx_byte} == idref_r) & ~act_inf_r;
                  o_id_fail <= o_id_fail | ({act_d0_r, i_rx_byte} != idref_r) | act_inf_r;
               end else if ((act_cnt_r == 3'h2) & act_inf_r) begin
                  id_ok_r <= ({act_d0_r, act_d1_r} == idref_r);
                  o_id_fail <= o_id_fail | ({act_d0_r, act_d1_r} != idref_r);
                  // top nibble is reserved and dropped
                  cap_r <= {4'h0, i_rx_byte[3:0]};
                  cap_seen_r <= ~act_done_r;
                  o_ext_fast_ok <= ~act_done_r & i_rx_byte[`CAP_FAST_BIT];
                  o_ext_slow_ok <= ~act_done_r & i_rx_byte[`CAP_SLOW_BIT];
               end
            end
            is_act_r <= 1'b0;
         end
      end
   end
end
// legacy request: software wants it, identity good, all shdlc frames acked
always @(posedge i_clk or posedge i_rst) begin
   if (i_rst)
      open_legacy_req_r <= 1'b0;
   else
      open_legacy_req_r <= i_activated & want_legacy_r & sync_seen_r & id_ok_r & ~o_id_fail
         & i_shdlc_all_acked;
end
// ****************************************
// activation transmit: power select frame
// ****************************************
wire cap_rx_ok;
// card only reads the info flag once it has announced that it can
assign cap_rx_ok = cap_seen_r & cap_r[`CAP_RXINFO_BIT];
always @(posedge i_clk or posedge i_rst) begin
   if (i_rst) begin
      tx_st_r <= TX_IDLE;
      o_tx_byte <= 8'h00;
      o_tx_valid <= 1'b0;
      o_tx_last <= 1'b0;
   end else begin
      case (tx_st_r)
         TX_IDLE: begin
            // front-end only ever sends power select; card sends the rest
            if (send_pwr_r & ~link_up & i_activated) begin
               o_tx_byte <= {`LLC_ACT_TOP, 1'b0, cap_rx_ok, `ACT_CODE_POWER};
               o_tx_valid <= 1'b1;
               o_tx_last <= 1'b0;
               tx_st_r <= TX_CTRL;
            end
         end
         TX_CTRL: begin
            if (i_tx_ready) begin
               o_tx_byte <= pwr_full_r ? `PWR_FULL : `PWR_LOW;
               o_tx_last <= ~cap_rx_ok;
               tx_st_r <= TX_DATA;
            end
         end
         TX_DATA: begin
            if (i_tx_ready) begin
               if (cap_rx_ok) begin
                  o_tx_byte <= {7'h00, rf_cause_r};
                  o_tx_last <= 1'b1;
                  tx_st_r <= TX_INFO;
               end else begin
                  o_tx_valid <= 1'b0;
                  o_tx_last <= 1'b0;
                  tx_st_r <= TX_IDLE;
               end
            end
         end
         TX_INFO: begin
            if (i_tx_ready) begin
               o_tx_valid <= 1'b0;
               o_tx_last <= 1'b0;
               tx_st_r <= TX_IDLE;
            end
         end
         default: tx_st_r <= TX_IDLE;
      endcase
   end
end
endmodule // llc_dispatch

// ---- hdl/llc_dispatch_regs.vh ----
// constants for the link-layer dispatch block of the contactless front-end
// assumes includers use the values at the widths given here
`ifndef LLC_DISPATCH_REGS_VH
`define LLC_DISPATCH_REGS_VH
// ****************************************
// register byte offsets
// ****************************************
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_IDREF 12'h008
`define REG_RXINFO 12'h00c
`define REG_TXCMD 12'h010
// ****************************************
// control byte decode
// ****************************************
`define LLC_ACT_TOP 3'h3
`define LLC_LEG_TOP 3'h2
`define ACT_CODE_READY 3'h0
`define ACT_CODE_POWER 3'h2
`define ACT_CODE_SYNC 3'h1
// ****************************************
// field positions and power byte values
// ****************************************
`define ACT_HINT_BIT 4
`define ACT_INF_BIT 3
`define CAP_RXINFO_BIT 3
`define CAP_XRESUME_BIT 2
`define CAP_FAST_BIT 1
`define CAP_SLOW_BIT 0
`define PWR_LOW 8'h00
`define PWR_FULL 8'h01
// ****************************************
// owner encoding and identity reset value
// ****************************************
`define OWN_ACT 2'h0
`define OWN_SHDLC 2'h1
`define OWN_LEG 2'h2
`define IDREF_RESET 16'h0000
`endif

// ---- verif/llc_dispatch_chk.sv ----
// checker for the link-layer dispatch block
// assumes it is bound onto llc_dispatch, one clock domain
`timescale 1ns/1ps
module llc_dispatch_chk (
   // clock and reset
   input wire i_clk,
   input wire i_rst,
   // received payload and status inputs
   input wire i_activated,
   input wire [7:0] i_rx_byte,
   input wire i_rx_valid,
   input wire i_rx_first,
   input wire i_rx_last,
   input wire i_rx_bad,
   input wire i_shdlc_all_acked,
   // design outputs
   input wire [7:0] o_out_byte,
   input wire o_out_shdlc,
   input wire o_out_legacy,
   input wire [7:0] o_tx_byte,
   input wire o_tx_valid,
   input wire [1:0] o_recover_owner,
   input wire o_legacy_open,
   input wire o_ext_fast_ok,
   input wire o_id_fail
);
   // ****************************************
   // frame type tracking
   // ****************************************
   reg shdlc_r;
   wire good1 = i_rx_valid & i_rx_first & !i_rx_bad;
   // later bytes inherit the type of their control byte
   wire sh_now = i_rx_first ? i_rx_byte[7] : shdlc_r;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) shdlc_r <= 1'b0;
      else if (good1) shdlc_r <= i_rx_byte[7];
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ****************************************
   // assertions
   // ****************************************
   act_drop_a: assert property (good1 && i_rx_byte[7:5] == 3'h3 |=> !o_out_shdlc && !o_out_legacy)
      else $error("activation byte forwarded");
   shdlc_fwd_a: assert property (good1 && i_rx_byte[7] |=> o_out_shdlc && o_out_byte == $past(i_rx_byte))
      else $error("shdlc byte not forwarded");
   deact_clr_a: assert property (!i_activated |=> !o_legacy_open && !o_id_fail)
      else $error("state kept over deactivation");
   leg_close_a: assert property (o_legacy_open && good1 && i_rx_byte[7] |-> ##[1:32] !o_legacy_open)
      else $error("legacy not closed by shdlc");
   bad_keep_a: assert property (i_rx_valid && i_rx_bad |=> $stable(o_recover_owner))
      else $error("owner moved on bad frame");
   own_shdlc_a: assert property (i_rx_valid && i_rx_last && !i_rx_bad && sh_now |-> ##[1:2] o_recover_owner == 2'h1)
      else $error("owner not shdlc");
   leg_ack_a: assert property ($rose(o_legacy_open) |-> $past(i_shdlc_all_acked))
      else $error("legacy opened with unacked frames");
   leg_id_a: assert property (o_id_fail |-> !o_legacy_open)
      else $error("legacy open after failed identity");
   tx_hdr_a: assert property ($rose(o_tx_valid) |-> o_tx_byte[7:4] == 4'h6 && o_tx_byte[2:0] == 3'h2 && !o_legacy_open)
      else $error("bad power frame header");
   ext_cap_a: assert property ($rose(o_ext_fast_ok) |-> $past(i_rx_valid && i_rx_last && i_rx_byte[1]))
      else $error("extended timing without capability");
   fail_hold_a: assert property (o_id_fail && i_activated |=> o_id_fail)
      else $error("identity fail flag dropped");
   cover property (good1 && i_rx_byte[7:5] == 3'h2);
   cover property ($rose(o_legacy_open));
   cover property ($rose(o_tx_valid));
endmodule // llc_dispatch_chk
bind llc_dispatch llc_dispatch_chk i_llc_dispatch_chk (.i_clk, .i_rst, .i_activated, .i_rx_byte, .i_rx_valid,
   .i_rx_first, .i_rx_last, .i_rx_bad, .i_shdlc_all_acked, .o_out_byte, .o_out_shdlc, .o_out_legacy, .o_tx_byte,
   .o_tx_valid, .o_recover_owner, .o_legacy_open, .o_ext_fast_ok, .o_id_fail);

// ---- verif/card_model.sv ----
// card endpoint model: sends payload frames, takes power frames with random stalls
// assumes send() is called just after a rising edge
`timescale 1ns/1ps
module card_model (
   // clock
   input wire i_clk,
   // payload toward the front-end
   output logic [7:0] o_rx_byte,
   output logic o_rx_valid,
   output logic o_rx_first,
   output logic o_rx_last,
   output logic o_rx_bad,
   // frames from the front-end
   input wire i_tx_valid,
   input wire [7:0] i_tx_byte,
   input wire i_tx_last,
   output logic o_tx_ready
);
   // power mode as the card takes it: low power until a power frame says otherwise
   logic low_power = 1'b1;
   logic [1:0] tx_pos = 2'h0;
   always @(posedge i_clk) begin
      if (i_tx_valid && o_tx_ready) begin
         if (tx_pos == 2'h1) low_power <= i_tx_byte == 8'h00;
         tx_pos <= i_tx_last ? 2'h0 : tx_pos + 2'h1;
      end
   end
   initial begin
      o_rx_byte = 8'h00;
      o_rx_valid = 1'b0;
      o_rx_first = 1'b0;
      o_rx_last = 1'b0;
      o_rx_bad = 1'b0;
      o_tx_ready = 1'b0;
   end
   // a slow card stalls now and then
   always @(posedge i_clk) o_tx_ready <= ($urandom % 3) != 0;
   task send(input logic [7:0] f[$], input bit bad);
      logic [7:0] b;
      for (int i = 0; i < f.size(); i++) begin
         b = f[i];
         if (i == 0 && b[7:5] == 3'h3) b[4] = 1'b0;
         @(posedge i_clk);
         o_rx_valid <= 1'b1;
         o_rx_byte <= b;
         o_rx_first <= i == 0;
         o_rx_last <= i == f.size() - 1;
         o_rx_bad <= bad && i == f.size() - 1;
      end
      @(posedge i_clk);
      o_rx_valid <= 1'b0;
      o_rx_last <= 1'b0;
      o_rx_bad <= 1'b0;
      // released data never keeps the last value
      o_rx_byte <= ~b;
   endtask
endmodule // card_model

// ---- verif/testbench.sv ----
// self-checking bench for the link-layer dispatch block
// assumes card_model on the far side and the bound checker
`timescale 1ns/1ps
`include "llc_dispatch_regs.vh"
module testbench;
   logic i_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   logic [11:0] i_awaddr, i_araddr;
   logic [31:0] i_wdata;
   logic [3:0] i_wstrb;
   logic i_activated, i_shdlc_established, i_shdlc_all_acked;
   wire [7:0] i_rx_byte, o_out_byte, o_tx_byte;
   wire i_rx_valid, i_rx_first, i_rx_last, i_rx_bad, i_tx_ready, o_awready, o_wready, o_bvalid, o_arready;
   wire o_rvalid, o_out_shdlc, o_out_legacy, o_out_last, o_tx_valid, o_tx_last;
   wire o_legacy_open, o_ext_fast_ok, o_ext_slow_ok, o_id_fail;
   wire [1:0] o_bresp, o_rresp, o_recover_owner;
   wire [31:0] o_rdata;
   int n_mismatch, comparisons;
   logic [10:0] oq[$];
   logic [8:0] tq[$];
   llc_dispatch i_llc_dispatch (.*);
   card_model i_card_model (.i_clk, .o_rx_byte(i_rx_byte), .o_rx_valid(i_rx_valid), .o_rx_first(i_rx_first),
      .o_rx_last(i_rx_last), .o_rx_bad(i_rx_bad), .i_tx_valid(o_tx_valid), .i_tx_byte(o_tx_byte),
      .i_tx_last(o_tx_last), .o_tx_ready(i_tx_ready));
   // ****************************************
   // checking and closing
   // ****************************************
   task chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task close_out;
      $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task tmo(input bit ok);
      if (!ok) begin
         n_mismatch++;
         close_out;
      end
   endtask
   always @(negedge i_clk) begin
      if (o_out_shdlc | o_out_legacy) begin
         if (oq.size() == 0) chk(1, 0);
         else chk({o_out_shdlc, o_out_legacy, o_out_last, o_out_byte}, oq.pop_front());
      end
      if (o_tx_valid & i_tx_ready) begin
         if (tq.size() == 0) chk(1, 0);
         else chk({o_tx_last, o_tx_byte}, tq.pop_front());
      end
   end
   // ****************************************
   // bus and frame tasks
   // ****************************************
   // handshakes are sampled at the falling edge, so the rising edge never races
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      bit ta, tw, tb;
      logic [1:0] s;
      tb = 0;
      @(posedge i_clk);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1;
      i_wvalid <= 1;
      i_bready <= 1;
      repeat (40) if (!tb) begin
         @(negedge i_clk);
         ta = i_awvalid & o_awready;
         tw = i_wvalid & o_wready;
         tb = o_bvalid;
         s = o_bresp;
         @(posedge i_clk);
         if (ta) i_awvalid <= 0;
         if (tw) i_wvalid <= 0;
      end
      i_bready <= 0;
      tmo(tb);
      chk(s, r);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
      bit ta, tr;
      logic [31:0] d;
      logic [1:0] s;
      tr = 0;
      @(posedge i_clk);
      i_araddr <= a;
      i_arvalid <= 1;
      i_rready <= 1;
      repeat (40) if (!tr) begin
         @(negedge i_clk);
         ta = i_arvalid & o_arready;
         tr = o_rvalid;
         d = o_rdata;
         s = o_rresp;
         @(posedge i_clk);
         if (ta) i_arvalid <= 0;
      end
      i_rready <= 0;
      tmo(tr);
      chk(s, r);
      chk(d, e);
   endtask
   task fr(input logic [7:0] f[$], input logic [1:0] k, input bit bad = 0);
      // last flag stands only on a non-first closing byte
      foreach (f[i]) if (k != 0) oq.push_back({k, (i == f.size() - 1 && i != 0), f[i]});
      i_card_model.send(f, bad);
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
   endtask
   task drain;
      repeat (60) if (tq.size() != 0) @(posedge i_clk);
      tmo(tq.size() == 0);
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
   endtask
   task rnd_shdlc;
      logic [7:0] f[$];
      f = {8'h80 | 8'($urandom)};
      repeat ($urandom % 4) f.push_back(8'($urandom));
      fr(f, 2'b10);
   endtask
   // ****************************************
   // clock, watchdog, sequence
   // ****************************************
   initial begin
      i_clk = 0;
      forever #12.5 i_clk = ~i_clk;
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      n_mismatch++;
      close_out;
   end
   initial begin
      void'($urandom(32'h322bbd5f));
      {i_rst, i_wstrb} = 5'h1f;
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_awaddr, i_araddr, i_wdata} = 0;
      {i_activated, i_shdlc_established, i_shdlc_all_acked} = 0;
      repeat (5) @(posedge i_clk);
      i_rst <= 0;
      rd(`REG_IDREF, {16'h0, `IDREF_RESET}, 2'h0);
      rd(12'h100, 0, 2'h2);
      wr(`REG_STATUS, 1, 2'h2);
      wr(`REG_IDREF, 32'h5a5a, 0);
      rd(`REG_IDREF, 32'h5a5a, 0);
      @(posedge i_clk) i_activated <= 1;
      i_shdlc_all_acked <= 1;
      wr(`REG_CTRL, 1, 0);
      fr({8'h61, 8'h12, 8'h34}, 0);
      chk(o_id_fail, 1);
      chk(o_legacy_open, 0);
      tq = {9'h062, 9'h100};
      wr(`REG_TXCMD, 1, 0);
      drain;
      chk(i_card_model.low_power, 1);
      fr({8'h67}, 0);
      fr({8'h3f}, 0);
      fr({8'h40}, 0, 1);
      chk(o_recover_owner, `OWN_ACT);
      rnd_shdlc;
      chk(o_recover_owner, `OWN_SHDLC);
      @(posedge i_clk) i_activated <= 0;
      i_shdlc_all_acked <= 0;
      repeat (3) @(negedge i_clk);
      chk(o_id_fail, 0);
      @(posedge i_clk) i_activated <= 1;
      wr(`REG_CTRL, 7, 0);
      fr({8'h69, 8'h5a, 8'h5a, 8'hfe}, 0);
      chk({o_id_fail, o_ext_fast_ok, o_ext_slow_ok, o_recover_owner}, 5'h08);
      rd(`REG_RXINFO, 32'h5a5a0e, 0);
      tq = {9'h06a, 9'h001, 9'h101};
      wr(`REG_TXCMD, 1, 0);
      drain;
      chk(i_card_model.low_power, 0);
      chk(o_legacy_open, 0);
      @(posedge i_clk) i_shdlc_all_acked <= 1;
      repeat (10) if (o_legacy_open !== 1) @(negedge i_clk);
      chk(o_legacy_open, 1);
      fr({8'h41, 8'h22}, 2'b01);
      chk(o_recover_owner, `OWN_LEG);
      fr({8'h61, 8'h00, 8'h00}, 0);
      chk(o_id_fail, 0);
      wr(`REG_TXCMD, 1, 0);
      fr({8'h60}, 0, 1);
      chk(o_recover_owner, `OWN_ACT);
      wr(`REG_CTRL, 6, 0);
      rnd_shdlc;
      chk(o_legacy_open, 0);
      @(posedge i_clk) i_shdlc_established <= 1;
      wr(`REG_TXCMD, 1, 0);
      drain;
      chk(oq.size(), 0);
      close_out;
   end
endmodule // testbench
